// ---- shared/ccg_defs.vh ----
`ifndef CCG_DEFS_VH
`define CCG_DEFS_VH

// -----------------------------------------------------------------
// governor control register layout
// -----------------------------------------------------------------
`define CCG_GOV_EN_BIT 7
`define CCG_WIDTH_HI 4
`define CCG_WIDTH_LO 0
`define CCG_WIDTH_FULL 5'h1f
`define CCG_WIDTH_ZERO 5'h00
`define CCG_GOV_EN_RST 1'b0

// -----------------------------------------------------------------
// synth control register layout
// -----------------------------------------------------------------
`define CCG_SYNTH_OFF_BIT 3
`define CCG_WAKE_SEL_HI 1
`define CCG_WAKE_SEL_LO 0
`define CCG_WAKE_SEL_RST 2'h3

// -----------------------------------------------------------------
// timing counts
// -----------------------------------------------------------------
`define CCG_FRAME_LAST 5'h1e
`define CCG_STOP_CYCLES 5'h1e
`define CCG_WAKE_D00 7'h20
`define CCG_WAKE_D01 7'h30
`define CCG_WAKE_D10 7'h40
`define CCG_WAKE_D11 7'h60

// -----------------------------------------------------------------
// mode codes shown on the status port
// -----------------------------------------------------------------
`define CCG_MODE_NORMAL 2'h0
`define CCG_MODE_BURST 2'h1
`define CCG_MODE_DOZE 2'h2
`define CCG_MODE_SLEEP 2'h3

`endif

// ---- core/ccg_sync3.v ----
`timescale 1ns/10ps
// three-stage synchroniser with agreement filter and rise tick
module ccg_sync3 (
    input wire clk_in,
    input wire rst_in,
    input wire async_in,
    output reg level_out,
    output reg rise_out
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    // -------------------------------------------------------------
    // capture chain
    // -------------------------------------------------------------
    // only s2 reads s1
    always @(posedge clk_in) begin
        if (rst_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // -------------------------------------------------------------
    // filtered level and rise pulse
    // -------------------------------------------------------------
    // change taken once s2 and s3 agree
    always @(posedge clk_in) begin
        if (rst_in) begin
            level_out <= 1'b0;
            rise_out <= 1'b0;
        end else begin
            rise_out <= 1'b0;
            if (s2_q == s3_q) begin
                level_out <= s3_q;
                rise_out <= s3_q & ~level_out;
            end
        end
    end

endmodule // ccg_sync3

// ---- core/ccg_down_cnt.v ----
`timescale 1ns/10ps
// loadable down counter with zero flag
module ccg_down_cnt #(
    parameter WIDTH = 7
) (
    input wire clk_in,
    input wire rst_in,
    input wire load_in,
    input wire [WIDTH-1:0] load_val_in,
    input wire step_in,
    output wire zero_out
);

    reg [WIDTH-1:0] cnt_q;

    // -------------------------------------------------------------
    // count
    // -------------------------------------------------------------
    // load has priority, stop at zero
    always @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= {WIDTH{1'b0}};
        end else if (load_in) begin
            cnt_q <= load_val_in;
        end else if (step_in && (cnt_q != {WIDTH{1'b0}})) begin
            cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign zero_out = (cnt_q == {WIDTH{1'b0}});

endmodule // ccg_down_cnt

// ---- core/ccg_governor.v ----
`timescale 1ns/10ps
`include "ccg_defs.vh"
// core clock burst gating and sleep control
module ccg_governor #(
    parameter ADDR_W = 24,
    parameter LEVEL_W = 3
) (
    input wire CLK_IN,
    input wire SYS_RST_IN,
    input wire GOV_WR_IN,
    input wire [7:0] GOV_WDATA_IN,
    input wire SYNTH_WR_IN,
    input wire [7:0] SYNTH_WDATA_IN,
    input wire SLOW_CLK_IN,
    input wire WAKE_IN,
    input wire [LEVEL_W-1:0] WAKE_LEVEL_IN,
    input wire CORE_GRANT_IN,
    input wire DMA_BUSY_IN,
    input wire [ADDR_W-1:0] ADDR_IN,
    input wire RTC_IRQ_IN,
    output reg CORE_CLK_EN_OUT,
    output reg SYS_CLK_EN_OUT,
    output reg SYNTH_RUN_OUT,
    output reg CORE_BUS_REQ_OUT,
    output reg DMA_GRANT_OUT,
    output reg [ADDR_W-1:0] ADDR_OUT,
    output reg SLOW_TICK_OUT,
    output reg RTC_IRQ_OUT,
    output reg [LEVEL_W-1:0] IRQ_LEVEL_OUT,
    output reg IRQ_LEVEL_VALID_OUT,
    output reg [7:0] GOV_CTRL_OUT,
    output reg [7:0] SYNTH_CTRL_OUT,
    output reg [1:0] MODE_OUT
);

    // -------------------------------------------------------------
    // state codes
    // -------------------------------------------------------------
    localparam [1:0] C_RUN = 2'h0;
    localparam [1:0] C_REQ = 2'h1;
    localparam [1:0] C_OFF = 2'h2;
    localparam [1:0] C_RESUME = 2'h3;
    localparam [1:0] P_ON = 2'h0;
    localparam [1:0] P_STOPPING = 2'h1;
    localparam [1:0] P_ASLEEP = 2'h2;
    localparam [1:0] P_WAKING = 2'h3;

    // -------------------------------------------------------------
    // wake delay decode
    // -------------------------------------------------------------
    function [6:0] wake_delay;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: wake_delay = `CCG_WAKE_D00;
                2'h1: wake_delay = `CCG_WAKE_D01;
                2'h2: wake_delay = `CCG_WAKE_D10;
                default: wake_delay = `CCG_WAKE_D11;
            endcase
        end
    endfunction

    reg gov_en_q;
    reg gov_en_d;
    reg [4:0] width_q;
    reg [4:0] width_d;
    reg synth_off_q;
    reg synth_off_d;
    reg [1:0] wake_sel_q;
    reg [1:0] wake_sel_d;
    reg [4:0] frame_q;
    reg [4:0] frame_d;
    reg [1:0] cst_q;
    reg [1:0] cst_d;
    reg [1:0] pst_q;
    reg [1:0] pst_d;
    reg [LEVEL_W-1:0] lvl_q;
    reg [LEVEL_W-1:0] lvl_d;
    reg lvl_pend_q;
    reg lvl_pend_d;
    reg stop_load;
    reg wake_load;
    reg slot_on;
    reg sys_run;
    wire slow_level;
    wire slow_rise;
    wire stop_zero;
    wire wake_zero;

    // -------------------------------------------------------------
    // slow crystal clock sampling
    // -------------------------------------------------------------
    // slow clock is a pin, synchronised
    ccg_sync3 u_slow_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .async_in(SLOW_CLK_IN),
        .level_out(slow_level),
        .rise_out(slow_rise)
    );

    // -------------------------------------------------------------
    // delay counters
    // -------------------------------------------------------------
    // stop delay counts system cycles
    ccg_down_cnt #(
        .WIDTH(5)
    ) u_stop_cnt (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .load_in(stop_load),
        .load_val_in(`CCG_STOP_CYCLES - 5'h01),
        .step_in(1'b1),
        .zero_out(stop_zero)
    );

    // wake delay counts slow crystal periods
    ccg_down_cnt #(
        .WIDTH(7)
    ) u_wake_cnt (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .load_in(wake_load),
        .load_val_in(wake_delay(wake_sel_q)),
        .step_in(slow_rise),
        .zero_out(wake_zero)
    );

    // -------------------------------------------------------------
    // control register writes
    // -------------------------------------------------------------
    // wake clears enable, width kept
    always @* begin
        gov_en_d = gov_en_q;
        width_d = width_q;
        synth_off_d = synth_off_q;
        wake_sel_d = wake_sel_q;
        if (GOV_WR_IN) begin
            gov_en_d = GOV_WDATA_IN[`CCG_GOV_EN_BIT];
            width_d = GOV_WDATA_IN[`CCG_WIDTH_HI:`CCG_WIDTH_LO];
        end
        if (SYNTH_WR_IN) begin
            synth_off_d = SYNTH_WDATA_IN[`CCG_SYNTH_OFF_BIT];
            wake_sel_d = SYNTH_WDATA_IN[`CCG_WAKE_SEL_HI:`CCG_WAKE_SEL_LO];
        end
        if (WAKE_IN) begin
            gov_en_d = 1'b0;
        end
        if (WAKE_IN && (pst_q != P_ON)) begin
            synth_off_d = 1'b0;
        end
    end

    // -------------------------------------------------------------
    // burst frame position
    // -------------------------------------------------------------
    // frame of 31 slow periods, slot compare
    always @* begin
        frame_d = frame_q;
        if (slow_rise) begin
            if (frame_q == `CCG_FRAME_LAST) begin
                frame_d = 5'h00;
            end else begin
                frame_d = frame_q + 5'h01;
            end
        end
        if (!gov_en_q) begin
            slot_on = 1'b1;
        end else if (width_q == `CCG_WIDTH_FULL) begin
            slot_on = 1'b1;
        end else if (width_q == `CCG_WIDTH_ZERO) begin
            slot_on = 1'b0;
        end else begin
            slot_on = (frame_q < width_q);
        end
    end

    // -------------------------------------------------------------
    // core clock gate and bus handover
    // -------------------------------------------------------------
    // outside sleep, clock stops only after the core grants the bus
    always @* begin
        cst_d = cst_q;
        case (cst_q)
            C_RUN: begin
                if (!slot_on) begin
                    cst_d = C_REQ;
                end
            end
            C_REQ: begin
                if (slot_on) begin
                    cst_d = C_RUN;
                end else if (CORE_GRANT_IN) begin
                    cst_d = C_OFF;
                end
            end
            C_OFF: begin
                if (slot_on) begin
                    cst_d = C_RESUME;
                end
            end
            C_RESUME: begin
                if (!DMA_BUSY_IN) begin
                    cst_d = C_RUN;
                end
            end
            default: begin
                cst_d = C_RUN;
            end
        endcase
    end

    // -------------------------------------------------------------
    // synth shutdown and restart
    // -------------------------------------------------------------
    // stop after delay, restart after wake delay
    always @* begin
        pst_d = pst_q;
        stop_load = 1'b0;
        wake_load = 1'b0;
        case (pst_q)
            P_ON: begin
                if (synth_off_q) begin
                    pst_d = P_STOPPING;
                    stop_load = 1'b1;
                end
            end
            P_STOPPING: begin
                if (!synth_off_q) begin
                    pst_d = P_ON;
                end else if (stop_zero) begin
                    pst_d = P_ASLEEP;
                end
            end
            P_ASLEEP: begin
                if (!synth_off_q) begin
                    pst_d = P_WAKING;
                    wake_load = 1'b1;
                end
            end
            P_WAKING: begin
                if (wake_zero) begin
                    pst_d = P_ON;
                end
            end
            default: begin
                pst_d = P_ON;
            end
        endcase
        sys_run = (pst_d == P_ON) || (pst_d == P_STOPPING);
    end

    // -------------------------------------------------------------
    // wake level capture
    // -------------------------------------------------------------
    // level served once clocks are back
    always @* begin
        lvl_d = lvl_q;
        lvl_pend_d = lvl_pend_q;
        if (WAKE_IN) begin
            lvl_d = WAKE_LEVEL_IN;
            lvl_pend_d = 1'b1;
        end else if (lvl_pend_q && sys_run) begin
            lvl_pend_d = 1'b0;
        end
    end

    // -------------------------------------------------------------
    // state registers
    // -------------------------------------------------------------
    // reset places the device in normal mode
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            gov_en_q <= `CCG_GOV_EN_RST;
            width_q <= `CCG_WIDTH_FULL;
            synth_off_q <= 1'b0;
            wake_sel_q <= `CCG_WAKE_SEL_RST;
            frame_q <= 5'h00;
            cst_q <= C_RUN;
            pst_q <= P_ON;
            lvl_q <= {LEVEL_W{1'b0}};
            lvl_pend_q <= 1'b0;
        end else begin
            gov_en_q <= gov_en_d;
            width_q <= width_d;
            synth_off_q <= synth_off_d;
            wake_sel_q <= wake_sel_d;
            frame_q <= frame_d;
            cst_q <= cst_d;
            pst_q <= pst_d;
            lvl_q <= lvl_d;
            lvl_pend_q <= lvl_pend_d;
        end
    end

    // -------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------
    // every output taken from a flip-flop on a clock edge
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            CORE_CLK_EN_OUT <= 1'b1;
            SYS_CLK_EN_OUT <= 1'b1;
            SYNTH_RUN_OUT <= 1'b1;
            CORE_BUS_REQ_OUT <= 1'b0;
            DMA_GRANT_OUT <= 1'b0;
            ADDR_OUT <= {ADDR_W{1'b0}};
            SLOW_TICK_OUT <= 1'b0;
            RTC_IRQ_OUT <= 1'b0;
            IRQ_LEVEL_OUT <= {LEVEL_W{1'b0}};
            IRQ_LEVEL_VALID_OUT <= 1'b0;
            GOV_CTRL_OUT <= 8'h00;
            SYNTH_CTRL_OUT <= 8'h00;
            MODE_OUT <= `CCG_MODE_NORMAL;
        end else begin
            // gate enable changes only at edges
            CORE_CLK_EN_OUT <= sys_run && ((cst_d == C_RUN) || (cst_d == C_REQ));
            SYS_CLK_EN_OUT <= sys_run;
            SYNTH_RUN_OUT <= (pst_d != P_ASLEEP);
            CORE_BUS_REQ_OUT <= (cst_d != C_RUN);
            DMA_GRANT_OUT <= (cst_d == C_OFF) || (cst_d == C_RESUME);
            if (sys_run) begin
                ADDR_OUT <= ADDR_IN;
            end
            SLOW_TICK_OUT <= slow_rise;
            RTC_IRQ_OUT <= RTC_IRQ_IN;
            IRQ_LEVEL_OUT <= lvl_d;
            // pending level shown on the first edge with clocks running
            IRQ_LEVEL_VALID_OUT <= lvl_pend_q && sys_run;
            GOV_CTRL_OUT <= {gov_en_d, 2'h0, width_d};
            SYNTH_CTRL_OUT <= {4'h0, synth_off_d, 1'b0, wake_sel_d};
            // mode summary
            if (pst_d != P_ON) begin
                MODE_OUT <= `CCG_MODE_SLEEP;
            end else if (!gov_en_d) begin
                MODE_OUT <= `CCG_MODE_NORMAL;
            end else if (width_d == `CCG_WIDTH_ZERO) begin
                MODE_OUT <= `CCG_MODE_DOZE;
            end else begin
                MODE_OUT <= `CCG_MODE_BURST;
            end
        end
    end

    // slow level is used only through its tick
    wire unused_slow = slow_level;

endmodule // ccg_governor

// ---- verif/ccg_checker.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker for the core clock governor
// ------------------------------------------------------------
module ccg_checker #(
    parameter ADDR_W = 24
) (
    input wire CLK_IN,
    input wire SYS_RST_IN,
    input wire SYNTH_WR_IN,
    input wire [7:0] SYNTH_WDATA_IN,
    input wire WAKE_IN,
    input wire CORE_GRANT_IN,
    input wire DMA_BUSY_IN,
    input wire RTC_IRQ_IN,
    input wire [ADDR_W-1:0] ADDR_IN,
    input wire DMA_GRANT_OUT,
    input wire CORE_CLK_EN_OUT,
    input wire SYS_CLK_EN_OUT,
    input wire CORE_BUS_REQ_OUT,
    input wire [ADDR_W-1:0] ADDR_OUT,
    input wire RTC_IRQ_OUT,
    input wire [7:0] GOV_CTRL_OUT,
    input wire [1:0] MODE_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    // sleep request from a running system, then the stop window
    sequence s_sleep_cmd;
        SYNTH_WR_IN && SYNTH_WDATA_IN[3] && !WAKE_IN && SYS_CLK_EN_OUT && MODE_OUT != 2'h3;
    endsequence
    sequence s_stop_window;
        SYS_CLK_EN_OUT [*8] ##[20:27] $fell(SYS_CLK_EN_OUT);
    endsequence
    // wake outside sleep with the dma side idle
    sequence s_quiet_wake;
        (WAKE_IN && MODE_OUT != 2'h3 && !DMA_BUSY_IN) ##1 !DMA_BUSY_IN [*3];
    endsequence

    a_reset_state: assert property ($fell(SYS_RST_IN) |-> CORE_CLK_EN_OUT
        && SYS_CLK_EN_OUT && MODE_OUT == 2'h0 && !CORE_BUS_REQ_OUT)
        else $error("outputs wrong after reset");
    a_stop_after_grant: assert property ($fell(CORE_CLK_EN_OUT) && SYS_CLK_EN_OUT
        |-> $past(CORE_GRANT_IN) && $past(CORE_BUS_REQ_OUT))
        else $error("core clock stopped without grant");
    a_wake_clears_en: assert property (WAKE_IN |=> !GOV_CTRL_OUT[7])
        else $error("wake left governor enabled");
    a_wake_resume: assert property (s_quiet_wake |-> ##[0:1] CORE_CLK_EN_OUT)
        else $error("core clock not back after wake");
    a_dma_first: assert property ($rose(CORE_CLK_EN_OUT) && $past(SYS_CLK_EN_OUT)
        |-> !$past(DMA_BUSY_IN))
        else $error("core resumed during dma access");
    a_stop_delay: assert property (s_sleep_cmd |-> s_stop_window)
        else $error("system clock stop delay wrong");
    a_sleep_addr_hold: assert property (!SYS_CLK_EN_OUT ##1 !SYS_CLK_EN_OUT
        |-> $stable(ADDR_OUT))
        else $error("address moved during sleep");
    a_periph_clk_on: assert property (!SYS_CLK_EN_OUT |-> MODE_OUT == 2'h3)
        else $error("system clock off outside sleep");
    a_full_width_on: assert property (CORE_CLK_EN_OUT && GOV_CTRL_OUT[4:0] == 5'h1f
        |=> CORE_CLK_EN_OUT || !SYS_CLK_EN_OUT)
        else $error("core clock gated at full width");
    a_rtc_follow: assert property (1'b1 |=> RTC_IRQ_OUT == $past(RTC_IRQ_IN))
        else $error("real-time interrupt not passed");
    a_dma_grant_mirror: assert property (SYS_CLK_EN_OUT
        |-> DMA_GRANT_OUT == !CORE_CLK_EN_OUT)
        else $error("dma grant does not mirror core clock stop");
    a_addr_track: assert property (SYS_CLK_EN_OUT && !$past(SYS_RST_IN)
        |-> ADDR_OUT == $past(ADDR_IN))
        else $error("address copy not following while awake");
endmodule // ccg_checker

bind ccg_governor ccg_checker #(.ADDR_W(ADDR_W)) i_ccg_checker (
    .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .SYNTH_WR_IN(SYNTH_WR_IN),
    .SYNTH_WDATA_IN(SYNTH_WDATA_IN), .WAKE_IN(WAKE_IN), .CORE_GRANT_IN(CORE_GRANT_IN),
    .DMA_BUSY_IN(DMA_BUSY_IN), .RTC_IRQ_IN(RTC_IRQ_IN), .ADDR_IN(ADDR_IN),
    .DMA_GRANT_OUT(DMA_GRANT_OUT), .CORE_CLK_EN_OUT(CORE_CLK_EN_OUT),
    .SYS_CLK_EN_OUT(SYS_CLK_EN_OUT), .CORE_BUS_REQ_OUT(CORE_BUS_REQ_OUT),
    .ADDR_OUT(ADDR_OUT), .RTC_IRQ_OUT(RTC_IRQ_OUT), .GOV_CTRL_OUT(GOV_CTRL_OUT),
    .MODE_OUT(MODE_OUT));

// ---- verif/ccg_partner.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// core, dma and crystal stand-in
// ------------------------------------------------------------
module ccg_partner (
    input wire clk_in,
    input wire rst_in,
    input wire bus_req_in,
    input wire dma_grant_in,
    output logic core_grant_out,
    output logic dma_busy_out,
    output wire slow_clk_out
);
    logic [2:0] lag_q;
    logic xtal_q = 1'b0;

    // crystal free running, phase unrelated to the system clock
    always #101 xtal_q = ~xtal_q;
    assign slow_clk_out = xtal_q;

    // core grants after a varying lag, dma busy in short bursts
    always @(posedge clk_in) begin
        lag_q <= rst_in ? 3'h0 : lag_q + 3'h1;
        if (rst_in || !bus_req_in)
            core_grant_out <= 1'b0;
        else if (lag_q[1:0] == 2'h3)
            core_grant_out <= 1'b1;
        dma_busy_out <= !rst_in && dma_grant_in && lag_q[2];
    end
endmodule // ccg_partner

// ---- verif/ccg_governor_test.sv ----
`timescale 1ns/10ps
module ccg_governor_test;
    // ------------------------------------------------------------
    // stimulus, wiring and bookkeeping
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic gov_wr = 1'b0;
    logic synth_wr = 1'b0;
    logic wake = 1'b0;
    logic rtc = 1'b0;
    logic clr = 1'b0;
    logic [7:0] gov_wd = 8'h00;
    logic [7:0] synth_wd = 8'h00;
    logic [2:0] lvl = 3'h0;
    logic [23:0] addr = 24'h00_0000;
    logic [31:0] seed = 32'h6313_711c;
    wire grant, busy, slow, clk_en, sys_en, req, dgrant, tick, run, lvl_v;
    wire [23:0] addr_o;
    wire [2:0] lvl_o;
    wire [7:0] gov_o, syn_o;
    wire [1:0] mode;
    typedef struct {int kind; int lo; int hi;} note_t;
    note_t notes[$];
    string names[6] = '{"regs", "core_on", "ticks", "sys_on", "valid", "level"};
    int cnt[4];
    int cycles = 0;
    int num_errors = 0;
    int checks_done = 0;

    ccg_governor i_ccg_governor (
        .CLK_IN(clk), .SYS_RST_IN(rst), .GOV_WR_IN(gov_wr), .GOV_WDATA_IN(gov_wd),
        .SYNTH_WR_IN(synth_wr), .SYNTH_WDATA_IN(synth_wd), .SLOW_CLK_IN(slow),
        .WAKE_IN(wake), .WAKE_LEVEL_IN(lvl), .CORE_GRANT_IN(grant), .DMA_BUSY_IN(busy),
        .ADDR_IN(addr), .RTC_IRQ_IN(rtc), .CORE_CLK_EN_OUT(clk_en), .SYS_CLK_EN_OUT(sys_en),
        .SYNTH_RUN_OUT(run), .CORE_BUS_REQ_OUT(req), .DMA_GRANT_OUT(dgrant), .ADDR_OUT(addr_o),
        .SLOW_TICK_OUT(tick), .RTC_IRQ_OUT(), .IRQ_LEVEL_OUT(lvl_o),
        .IRQ_LEVEL_VALID_OUT(lvl_v), .GOV_CTRL_OUT(gov_o), .SYNTH_CTRL_OUT(syn_o),
        .MODE_OUT(mode));

    ccg_partner i_ccg_partner (
        .clk_in(clk), .rst_in(rst), .bus_req_in(req), .dma_grant_in(dgrant),
        .core_grant_out(grant), .dma_busy_out(busy), .slow_clk_out(slow));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic note(input int kind, input int lo, input int hi);
        notes.push_back('{kind, lo, hi});
        @(negedge clk);
    endtask

    task automatic regs(input logic [7:0] g, input logic [7:0] s, input logic [1:0] m,
                        input logic [1:0] ce);
        // synth runs in every mode but sleep
        note(0, {11'h000, m != 2'h3, g, s, m, ce}, {11'h000, m != 2'h3, g, s, m, ce});
    endtask

    task automatic wr(input logic gov, input logic [7:0] d);
        if (gov) begin
            gov_wr = 1'b1;
            gov_wd = d;
        end else begin
            synth_wr = 1'b1;
            synth_wd = d;
        end
        @(negedge clk);
        gov_wr = 1'b0;
        synth_wr = 1'b0;
    endtask

    task automatic wake_ev(input logic [2:0] l);
        wake = 1'b1;
        lvl = l;
        @(negedge clk);
        wake = 1'b0;
    endtask

    task automatic clear();
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // clock and background traffic
    always #10 clk = ~clk;
    always @(negedge clk) begin
        {addr, rtc} <= 25'(rnd());
    end

    // activity counters, oldest note against what is seen, hang limit
    always @(posedge clk) begin
        note_t n;
        logic [31:0] v;
        cycles <= cycles + 1;
        cnt[0] <= clr ? 0 : cnt[0] + (clk_en === 1'b1);
        cnt[1] <= clr ? 0 : cnt[1] + (tick === 1'b1);
        cnt[2] <= clr ? 0 : cnt[2] + (sys_en === 1'b1);
        cnt[3] <= clr ? 0 : cnt[3] + (lvl_v === 1'b1);
        if (notes.size() > 0) begin
            n = notes.pop_front();
            v = n.kind == 0 ? {11'h000, run, gov_o, syn_o, mode, clk_en, sys_en} :
                n.kind == 5 ? {29'h0000_0000, lvl_o} : cnt[n.kind - 1];
            checks_done++;
            if ((v >= n.lo && v <= n.hi) !== 1'b1) begin
                num_errors++;
                $display("[ERR] %s expected %0d..%0d seen %0d", names[n.kind], n.lo, n.hi, v);
            end
        end
        if (cycles > 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [4:0] w;
        logic [2:0] l;
        int d;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        regs(8'h1f, 8'h03, 2'h0, 2'h3);
        wr(1'b1, 8'h80);
        regs(8'h80, 8'h03, 2'h2, 2'h3);
        repeat (10) @(negedge clk);
        clear();
        repeat (200) @(negedge clk);
        note(1, 0, 0);
        wake_ev(3'h2);
        repeat (10) @(negedge clk);
        regs(8'h00, 8'h03, 2'h0, 2'h3);
        // full, single and random burst widths over one frame
        for (int i = 0; i < 3; i++) begin
            w = i == 0 ? 5'h1f : i == 1 ? 5'h01 : 5'h02 + 5'(rnd() % 28);
            wr(1'b1, {3'h4, w});
            regs({3'h4, w}, 8'h03, 2'h1, 2'h3);
            repeat (40) @(negedge clk);
            clear();
            repeat (313) @(negedge clk);
            note(1, w * 101 / 10 - 8, w * 101 / 10 + 8);
            wake_ev(3'h1);
            repeat (10) @(negedge clk);
        end
        // sleep and wake with every delay code
        for (int s = 0; s < 4; s++) begin
            l = 3'(rnd());
            d = 32 + 16 * s + (s == 3 ? 16 : 0);
            clear();
            wr(1'b0, {4'h0, 2'h2, 2'(s)});
            repeat (40) @(negedge clk);
            note(3, 30, 35);
            regs({3'h0, w}, {4'h0, 2'h2, 2'(s)}, 2'h3, 2'h0);
            clear();
            wake_ev(l);
            repeat (1200) if (sys_en !== 1'b1) @(negedge clk);
            note(2, d - 2, d + 3);
            note(4, 1, 1);
            note(5, l, l);
            repeat (10) @(negedge clk);
        end
        report_and_stop();
    end
endmodule // ccg_governor_test
